// *** shared/dinp_pkg.sv ***
// constants and carrier types for the isolated digital input port
// assumes a 250 MHz pclk and an apb master on the register side
package dinp_pkg;

	// ==========================================================
	// geometry
	localparam int unsigned DINP_NCH = 32;
	localparam int unsigned DINP_DW = 32;
	localparam int unsigned DINP_AW = 8;
	localparam int unsigned DINP_FW = 8;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] DINP_OFF_DATA = 8'h00;
	localparam logic [7:0] DINP_OFF_IEN = 8'h04;
	localparam logic [7:0] DINP_OFF_EDGE = 8'h08;
	localparam logic [7:0] DINP_OFF_STAT = 8'h0c;
	localparam logic [7:0] DINP_OFF_FILT = 8'h10;
	localparam logic [7:0] DINP_OFF_RAW = 8'h14;

	// ==========================================================
	// values after reset
	localparam logic [31:0] DINP_IEN_RST = 32'h0000_0000;
	localparam logic [31:0] DINP_EDGE_RST = 32'h0000_0000;
	localparam logic [31:0] DINP_STAT_RST = 32'h0000_0000;
	localparam logic [7:0] DINP_FILT_RST = 8'h00;
	// idle pin level is high, which reads as zero
	localparam logic DINP_PIN_IDLE = 1'b1;

	// ==========================================================
	// timing: filter sample tick
	localparam int unsigned DINP_CLK_PS = 4000;
	localparam int unsigned DINP_TICK_NS = 1;
	localparam int unsigned DINP_TICK_US = 1;
	localparam int unsigned DINP_TICK_CYC =
		(DINP_TICK_US * 1000 * 1000) / DINP_CLK_PS;
	localparam int unsigned DINP_TW = 8;
	localparam logic [7:0] DINP_TICK_LAST = 8'(DINP_TICK_CYC - 1);

	// ==========================================================
	// apb carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [DINP_AW-1:0] paddr;
		logic [DINP_DW-1:0] pwdata;
	} dinp_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [DINP_DW-1:0] prdata;
	} dinp_apb_rsp_t;

endpackage

// *** design/dinp_filter.sv ***
// one channel of the noise and chatter filter
// assumes raw_pin is synchronous to pclk and tick is a one-cycle pulse
`timescale 1ns/1ps
module dinp_filter
	import dinp_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic tick,
	input wire logic [DINP_FW-1:0] limit,
	// channel
	input wire logic raw_pin,
	output logic filt_pin
);

	logic lvl_q;
	logic lvl_d;
	logic [DINP_FW-1:0] cnt_q;
	logic [DINP_FW-1:0] cnt_d;

	// ==========================================================
	// stability counter
	always_comb
	begin
		lvl_d = lvl_q;
		cnt_d = cnt_q;
		if (raw_pin == lvl_q)
		begin
			// any return to the held level restarts the count
			cnt_d = '0;
		end
		else if (limit == '0)
		begin
			lvl_d = raw_pin;
			cnt_d = '0;
		end
		else if (tick)
		begin
			if ((cnt_q + 1'b1) >= limit)
			begin
				lvl_d = raw_pin;
				cnt_d = '0;
			end
			else
			begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lvl_q <= DINP_PIN_IDLE;
			cnt_q <= '0;
		end
		else
		begin
			lvl_q <= lvl_d;
			cnt_q <= cnt_d;
		end
	end

	assign filt_pin = lvl_q;

endmodule

// *** design/dinp_top.sv ***
// isolated 32-channel digital input port with edge interrupts
// assumes field pins synchronous to pclk, apb master on the host side
`timescale 1ns/1ps
module dinp_top
	import dinp_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// register bus
	input wire dinp_apb_req_t apb_req,
	output dinp_apb_rsp_t apb_rsp,
	// field inputs
	input wire logic [DINP_NCH-1:0] din_pin,
	// interrupt
	output logic inta_n
);

	// ==========================================================
	// filter sample tick divider
	logic [DINP_TW-1:0] div_q;
	logic [DINP_TW-1:0] div_d;
	logic tick_q;
	logic tick_d;

	always_comb
	begin
		tick_d = 1'b0;
		if (div_q == DINP_TICK_LAST)
		begin
			div_d = '0;
			tick_d = 1'b1;
		end
		else
		begin
			div_d = div_q + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_q <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			div_q <= div_d;
			tick_q <= tick_d;
		end
	end

	// ==========================================================
	// register state
	logic [DINP_NCH-1:0] ien_q;
	logic [DINP_NCH-1:0] ien_d;
	logic [DINP_NCH-1:0] edge_q;
	logic [DINP_NCH-1:0] edge_d;
	logic [DINP_NCH-1:0] stat_q;
	logic [DINP_NCH-1:0] stat_d;
	logic [DINP_FW-1:0] filt_q;
	logic [DINP_FW-1:0] filt_d;

	// ==========================================================
	// per-channel filter and edge detection
	logic [DINP_NCH-1:0] lvl;
	logic [DINP_NCH-1:0] prev_q;
	logic [DINP_NCH-1:0] hit;

	genvar gi;
	generate
		for (gi = 0; gi < DINP_NCH; gi++)
		begin : g_ch
			dinp_filter u_filt (
				.pclk(pclk),
				.presetn(presetn),
				.tick(tick_q),
				.limit(filt_q),
				.raw_pin(din_pin[gi]),
				.filt_pin(lvl[gi])
			);
			assign hit[gi] = edge_q[gi] ? (lvl[gi] & ~prev_q[gi])
				: (~lvl[gi] & prev_q[gi]);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev_q <= {DINP_NCH{DINP_PIN_IDLE}};
		end
		else
		begin
			prev_q <= lvl;
		end
	end

	// ==========================================================
	// bus decode
	logic setup;
	logic wr_fire;
	logic hit_data;
	logic hit_ien;
	logic hit_edge;
	logic hit_stat;
	logic hit_filt;
	logic hit_raw;
	logic mapped;

	assign setup = apb_req.psel & ~apb_req.penable;
	// zero-wait access: write lands on the access edge
	assign wr_fire = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign hit_data = (apb_req.paddr == DINP_OFF_DATA);
	assign hit_ien = (apb_req.paddr == DINP_OFF_IEN);
	assign hit_edge = (apb_req.paddr == DINP_OFF_EDGE);
	assign hit_stat = (apb_req.paddr == DINP_OFF_STAT);
	assign hit_filt = (apb_req.paddr == DINP_OFF_FILT);
	assign hit_raw = (apb_req.paddr == DINP_OFF_RAW);
	assign mapped = hit_data | hit_ien | hit_edge | hit_stat | hit_filt
		| hit_raw;

	// ==========================================================
	// register writes and status latch
	always_comb
	begin
		ien_d = ien_q;
		edge_d = edge_q;
		filt_d = filt_q;
		stat_d = stat_q;
		if (wr_fire && hit_ien)
		begin
			ien_d = apb_req.pwdata;
		end
		if (wr_fire && hit_edge)
		begin
			edge_d = apb_req.pwdata;
		end
		if (wr_fire && hit_filt)
		begin
			filt_d = apb_req.pwdata[DINP_FW-1:0];
		end
		// write one to clear
		if (wr_fire && hit_stat)
		begin
			stat_d = stat_d & ~apb_req.pwdata;
		end
		// latch edge; a new event beats a same-cycle clear
		stat_d = stat_d | hit;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ien_q <= DINP_IEN_RST;
			edge_q <= DINP_EDGE_RST;
			stat_q <= DINP_STAT_RST;
			filt_q <= DINP_FILT_RST;
		end
		else
		begin
			ien_q <= ien_d;
			edge_q <= edge_d;
			stat_q <= stat_d;
			filt_q <= filt_d;
		end
	end

	// ==========================================================
	// read data, captured in the setup cycle
	logic [DINP_DW-1:0] rd_q;
	logic [DINP_DW-1:0] rd_d;
	logic err_q;
	logic err_d;

	always_comb
	begin
		rd_d = rd_q;
		err_d = err_q;
		if (setup)
		begin
			err_d = ~mapped;
			rd_d = '0;
			if (!apb_req.pwrite)
			begin
				if (hit_data)
				begin
					rd_d = ~lvl;
				end
				if (hit_raw)
				begin
					rd_d = ~din_pin;
				end
				if (hit_ien)
				begin
					rd_d = ien_q;
				end
				if (hit_edge)
				begin
					rd_d = edge_q;
				end
				if (hit_stat)
				begin
					rd_d = stat_q;
				end
				if (hit_filt)
				begin
					rd_d = {{(DINP_DW-DINP_FW){1'b0}}, filt_q};
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_q <= '0;
			err_q <= 1'b0;
		end
		else
		begin
			rd_q <= rd_d;
			err_q <= err_d;
		end
	end

	always_comb
	begin
		apb_rsp.pready = apb_req.psel & apb_req.penable;
		apb_rsp.pslverr = apb_req.psel & apb_req.penable & err_q;
		apb_rsp.prdata = rd_q;
	end

	// ==========================================================
	// interrupt request
	logic irq_q;
	logic irq_d;

	always_comb
	begin
		// masked bits never reach the request
		// one level request for all channels
		irq_d = |(stat_q & ien_q);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_q <= 1'b0;
		end
		else
		begin
			irq_q <= irq_d;
		end
	end

	// level held low while any enabled status bit stands
	assign inta_n = ~irq_q;

endmodule

// *** dv/dinp_assertions.sv ***
// port checker for the isolated input port top
// assumes dinp_top ports and the single pclk domain
`timescale 1ns/1ps
module dinp_checker
	import dinp_pkg::*;
(
	// watched ports
	input wire logic pclk,
	input wire logic presetn,
	input wire dinp_apb_req_t apb_req,
	input wire dinp_apb_rsp_t apb_rsp,
	input wire logic [DINP_NCH-1:0] din_pin,
	input wire logic inta_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic acc = apb_req.psel & apb_req.penable;
	wire logic wr = acc & apb_req.pwrite;
	sequence raw_setup;
		apb_req.psel && !apb_req.penable && !apb_req.pwrite
			&& apb_req.paddr == DINP_OFF_RAW;
	endsequence
	sequence ien_off;
		wr && apb_req.paddr == DINP_OFF_IEN && apb_req.pwdata == 32'h0;
	endsequence
	// ==========================================================
	// bus and interrupt relations
	chk_ready_now: assert property (acc |-> apb_rsp.pready)
		else $error("ready missing in access");
	chk_ready_idle: assert property (!apb_req.psel |-> !apb_rsp.pready)
		else $error("ready without select");
	chk_err_unmap: assert property (
		acc && apb_req.paddr > 8'h14 |-> apb_rsp.pslverr)
		else $error("unmapped access without error");
	chk_err_mapped: assert property (
		acc && apb_req.paddr[1:0] == 2'h0 && apb_req.paddr <= 8'h14
		|-> !apb_rsp.pslverr) else $error("error on mapped access");
	chk_write_zero: assert property (
		wr |-> apb_rsp.prdata == 32'h0) else $error("read data on write");
	chk_raw_invert: assert property (
		raw_setup |=> apb_rsp.prdata == ~$past(din_pin))
		else $error("raw read not inverted");
	chk_irq_hold: assert property (
		!inta_n && !wr && !$past(wr) |=> !inta_n)
		else $error("request dropped without clear");
	chk_ien_off: assert property (ien_off |-> ##[1:2] inta_n)
		else $error("request kept with enables off");
endmodule
bind dinp_top dinp_checker u_dinp_checker (.pclk(pclk), .presetn(presetn),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .din_pin(din_pin),
	.inta_n(inta_n));

// *** dv/dinp_host_model.sv ***
// host side bus master model for the input port
// assumes an apb slave on pclk that may add wait states
`timescale 1ns/1ps
module dinp_host_model
	import dinp_pkg::*;
(
	// clock
	input wire logic pclk,
	// register bus
	output dinp_apb_req_t apb_req,
	input wire dinp_apb_rsp_t apb_rsp
);
	initial apb_req = '0;
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge pclk);
		apb_req.psel <= 1'b1;
		apb_req.pwrite <= w;
		apb_req.paddr <= a;
		apb_req.pwdata <= wd;
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do
			@(posedge pclk);
		while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		// released data must not look valid
		apb_req.pwdata <= ~wd;
	endtask
endmodule

// *** dv/dinp_top_tb_top.sv ***
// self-checking bench for the isolated input port
// assumes the checker is bound in from its own file
`timescale 1ns/1ps
module dinp_top_tb_top
	import dinp_pkg::*;
();
	typedef struct {logic w; logic [7:0] a; logic [31:0] d, e; logic x;}
		dinp_row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [DINP_NCH-1:0] din_pin = '1;
	dinp_apb_req_t apb_req;
	dinp_apb_rsp_t apb_rsp;
	logic inta_n;
	logic [31:0] rd;
	logic err;
	int num_errors = 0;
	int check_count = 0;
	dinp_row_t rows[14] = '{
		'{1'b0, 8'h04, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h10, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0},
		'{1'b1, 8'h04, 32'h3, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h3, 1'b0},
		'{1'b1, 8'h08, 32'h2, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h2, 1'b0},
		'{1'b1, 8'h10, 32'h1ff, 32'h0, 1'b0},
		'{1'b0, 8'h10, 32'h0, 32'hff, 1'b0},
		'{1'b1, 8'h10, 32'h0, 32'h0, 1'b0},
		'{1'b1, 8'h00, 32'hffffffff, 32'h0, 1'b0},
		'{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1}};
	dinp_top u_dinp_top (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .din_pin(din_pin), .inta_n(inta_n));
	dinp_host_model u_dinp_host_model (.pclk(pclk), .apb_req(apb_req),
		.apb_rsp(apb_rsp));
	always #2 pclk = ~pclk;
	// ==========================================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// inta_n is looked at mid-cycle, away from the edge that launches it
	task automatic chk_irq(input logic exp);
		@(negedge pclk);
		chk({31'h0, inta_n}, {31'h0, exp});
		@(posedge pclk);
	endtask
	task automatic get(input logic [7:0] a, input logic [31:0] e);
		u_dinp_host_model.xfer(1'b0, a, 32'h0, rd, err);
		chk(rd, e);
	endtask
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		u_dinp_host_model.xfer(1'b1, a, d, rd, err);
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// hang guard, runs far past the expected 1500 or so cycles
	initial
	begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		close_out();
	end
	// ==========================================================
	// tests
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i])
		begin
			u_dinp_host_model.xfer(rows[i].w, rows[i].a, rows[i].d, rd, err);
			chk(rd, rows[i].e);
			chk({31'h0, err}, {31'h0, rows[i].x});
		end
		$display("register table done");
		din_pin[2:0] <= 3'b010;
		repeat (4) @(posedge pclk);
		get(8'h0c, 32'h5);
		chk_irq(1'b0);
		get(8'h00, 32'h5);
		din_pin[1] <= 1'b0;
		repeat (4) @(posedge pclk);
		get(8'h0c, 32'h5);
		din_pin[1] <= 1'b1;
		repeat (4) @(posedge pclk);
		get(8'h0c, 32'h7);
		put(8'h0c, 32'h1);
		repeat (3) @(posedge pclk);
		chk_irq(1'b0);
		put(8'h04, 32'h0);
		repeat (3) @(posedge pclk);
		chk_irq(1'b1);
		put(8'h04, 32'h3);
		repeat (3) @(posedge pclk);
		chk_irq(1'b0);
		put(8'h0c, 32'h2);
		repeat (3) @(posedge pclk);
		chk_irq(1'b1);
		get(8'h0c, 32'h4);
		$display("interrupt test done");
		put(8'h0c, 32'h4);
		put(8'h10, 32'h2);
		din_pin[3] <= 1'b0;
		// raw view follows the pin while the filtered view still holds
		get(8'h14, 32'hd);
		get(8'h00, 32'h5);
		repeat (100) @(posedge pclk);
		din_pin[3] <= 1'b1;
		repeat (600) @(posedge pclk);
		get(8'h00, 32'h5);
		get(8'h0c, 32'h0);
		din_pin[3] <= 1'b0;
		repeat (600) @(posedge pclk);
		get(8'h00, 32'hd);
		get(8'h0c, 32'h8);
		$display("filter test done");
		// pending request must be dropped by a mid-run reset
		put(8'h04, 32'h8);
		repeat (3) @(posedge pclk);
		chk_irq(1'b0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk_irq(1'b1);
		presetn <= 1'b1;
		get(8'h04, 32'h0);
		// low pins at release show up as falling edges
		get(8'h0c, 32'hd);
		chk_irq(1'b1);
		$display("reset test done");
		close_out();
	end
endmodule
